// ===== hw/spi_flash_params.svh
`ifndef SPI_FLASH_PARAMS_SVH
`define SPI_FLASH_PARAMS_SVH

// ****************************************
// Array geometry
// ****************************************
`define SF_SECTORS        2
`define SF_PAGES_PER_SEC  128
`define SF_PAGE_BYTES     256
`define SF_ADDR_W         16
`define SF_PAGE_LSB       8
`define SF_SECTOR_LSB     15
`define SF_PAGE_W         8
`define SF_COUNT_W        9

// ****************************************
// Reset values, guard codes and widths
// ****************************************
`define SF_GUARD_RST      2'h0
`define SF_GUARD_NONE     2'h0
`define SF_GUARD_ALL      2'h3
`define SF_TX_IDLE        8'hFF
`define SF_SYNC_W         3

// ****************************************
// Timing
// ****************************************
`define SF_SYS_CLK_MHZ    50
`define SF_HALF_NS        200
`define SF_HALF_CYC       ((`SF_HALF_NS * `SF_SYS_CLK_MHZ + 999) / 1000)

`endif

// ===== hw/spi_flash_pkg.sv
`include "spi_flash_params.svh"

package spi_flash_pkg;

   typedef logic [`SF_ADDR_W-1:0] sf_addr_t;

   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_LOW  = 4'b0010,
      H_HIGH = 4'b0100,
      H_END  = 4'b1000
   } host_st_t;

   typedef struct packed {
      logic [`SF_SYNC_W-1:0] sclk_s;
      logic [`SF_SYNC_W-1:0] cs_s;
      logic [`SF_SYNC_W-1:0] dat_s;
      logic [`SF_SYNC_W-1:0] pause_s;
      logic [`SF_SYNC_W-1:0] wp_s;
      logic                  sclk_lv;
      logic                  cs_n_lv;
      logic                  pause_n_lv;
      logic                  wp_n_lv;
      logic                  armed;
      logic                  hold;
      logic                  rose;
      logic [2:0]            bitcnt;
      logic [7:0]            rx_sh;
      logic [7:0]            rx_byte;
      logic                  push;
      logic [7:0]            tx_sh;
      logic                  q;
      logic                  q_oe;
      logic                  taken;
      logic                  overrun;
      logic [1:0]            guard;
      sf_addr_t              addr;
   } dev_st_t;

   typedef struct packed {
      host_st_t              st;
      logic [7:0]            ph;
      logic [2:0]            bitn;
      logic [7:0]            sh;
      logic [7:0]            rx;
      logic [7:0]            rx_data;
      logic                  rx_valid;
      logic [`SF_SYNC_W-1:0] miso_s;
      logic                  miso_lv;
      logic                  cpol;
      logic                  sclk;
      logic                  cs_n;
      logic                  mosi;
      logic                  pause_n;
   } host_reg_t;

   function automatic logic f_sector(input sf_addr_t a);
      return a[`SF_SECTOR_LSB];
   endfunction : f_sector

   function automatic logic [`SF_PAGE_W-1:0] f_page(input sf_addr_t a);
      return a[`SF_ADDR_W-1:`SF_PAGE_LSB];
   endfunction : f_page

   // Level after the second and third stages agree; else the old level
   function automatic logic f_agree(input logic [`SF_SYNC_W-1:0] s, input logic lv);
      return (s[1] == s[2]) ? s[2] : lv;
   endfunction : f_agree

endpackage : spi_flash_pkg

// ===== hw/spi_flash_if.sv
`timescale 1ns/100ps

interface spi_flash_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic pause_n;
   logic wp_n;
   logic miso_o;
   logic miso_oe;
   logic miso_line;

   // Undriven data line reads high, as through a pull-up
   assign miso_line = miso_oe ? miso_o : 1'b1;

   modport dev (
      input  sclk,
      input  cs_n,
      input  mosi,
      input  pause_n,
      input  wp_n,
      output miso_o,
      output miso_oe
   );

   modport host (
      output sclk,
      output cs_n,
      output mosi,
      output pause_n,
      output wp_n,
      input  miso_line
   );
endinterface : spi_flash_if

// ===== hw/two_entry_buf.sv
`timescale 1ns/100ps

module two_entry_buf #(
   parameter int W = 8,
   parameter int D = 2
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_in_data,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   output logic [W-1:0]      o_out_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } buf_st_t;

   buf_st_t r_ff;
   buf_st_t nxt_r;
   logic    push;
   logic    pop;

   assign o_in_ready  = (r_ff.cnt != (AW+1)'(D));
   assign o_out_valid = (r_ff.cnt != '0);
   assign o_out_data  = r_ff.mem[r_ff.rp];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   always_comb begin
      nxt_r = r_ff;
      if (push) begin
         nxt_r.mem[r_ff.wp] = i_in_data;
         nxt_r.wp = (r_ff.wp == AW'(D-1)) ? '0 : r_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_r.rp = (r_ff.rp == AW'(D-1)) ? '0 : r_ff.rp + 1'b1;
      end
      nxt_r.cnt = r_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end
endmodule : two_entry_buf

// ===== hw/flash_dev_end.sv
// Behaviour
// - Shift output bit after each serial falling edge that follows a rising edge
// - Capture input bit on each serial rising edge
// - Chip enable high: deselected, output floated
// - Standby only when deselected and not busy
// - Chip enable low selects, active power mode
// - No instruction before first chip enable fall
// - Pause floats output, ignores clock and data
// - Master pauses only while device selected
// - Protect input freezes the area guard bits
// - Support polarity/phase 0/0 and 1/1 only
// - Two sectors of 128 pages each, 256-byte pages
// - Page program writes 1 to 256 bytes
// - Erase whole array or one sector
// - Master selects only one device at once
// - Pause starts/ends with serial clock low
// - Pause never aborts a running internal cycle
`timescale 1ns/100ps

module flash_dev_end
   import spi_flash_pkg::*;
(
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst,
   spi_flash_if.dev                   link,
   output logic [7:0]                 o_rx_data,
   output logic                       o_rx_valid,
   input  wire logic                  i_rx_ready,
   output logic                       o_rx_overrun,
   input  wire logic [7:0]            i_tx_data,
   output logic                       o_tx_taken,
   input  wire logic                  i_busy,
   output logic                       o_selected,
   output logic                       o_active,
   output logic                       o_standby,
   output logic                       o_armed,
   output logic                       o_paused,
   input  wire logic                  i_guard_wr,
   input  wire logic [1:0]            i_guard_val,
   output logic [1:0]                 o_area_guard,
   output logic                       o_guard_frozen,
   input  wire logic                  i_addr_load,
   input  wire logic [`SF_ADDR_W-1:0] i_addr,
   input  wire logic                  i_addr_step,
   output logic [`SF_ADDR_W-1:0]      o_addr,
   output logic                       o_sector,
   output logic [`SF_PAGE_W-1:0]      o_page,
   output logic                       o_prog_ok,
   output logic                       o_sector_erase_ok,
   output logic                       o_bulk_erase_ok
);

   // ****************************************
   // State
   // ****************************************
   dev_st_t r_ff;
   dev_st_t nxt_r;
   logic    buf_in_ready;
   logic    sclk_now;
   logic    cs_n_now;
   logic    pause_n_now;
   logic    rise;
   logic    fall;
   logic    sel;
   logic    live;

   // ****************************************
   // Edge finding on the sampled pins
   // ****************************************
   always_comb begin
      sclk_now    = f_agree(r_ff.sclk_s, r_ff.sclk_lv);
      cs_n_now    = f_agree(r_ff.cs_s, r_ff.cs_n_lv);
      pause_n_now = f_agree(r_ff.pause_s, r_ff.pause_n_lv);
      // Edge usage is the same whatever level the clock idles at
      rise        = sclk_now & ~r_ff.sclk_lv;
      fall        = ~sclk_now & r_ff.sclk_lv;
      sel         = ~cs_n_now;
      // Nothing is decoded before the first select edge, nor while paused
      live        = sel & r_ff.armed & ~r_ff.hold;
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      nxt_r            = r_ff;
      nxt_r.sclk_s     = {r_ff.sclk_s[1:0], link.sclk};
      nxt_r.cs_s       = {r_ff.cs_s[1:0], link.cs_n};
      nxt_r.dat_s      = {r_ff.dat_s[1:0], link.mosi};
      nxt_r.pause_s    = {r_ff.pause_s[1:0], link.pause_n};
      nxt_r.wp_s       = {r_ff.wp_s[1:0], link.wp_n};
      nxt_r.sclk_lv    = sclk_now;
      nxt_r.cs_n_lv    = cs_n_now;
      nxt_r.pause_n_lv = pause_n_now;
      nxt_r.wp_n_lv    = f_agree(r_ff.wp_s, r_ff.wp_n_lv);
      nxt_r.push       = 1'b0;
      nxt_r.taken      = 1'b0;

      // While selected, pause changes state only while the clock is low; a pause requested
      // with the clock high waits for its next low phase.
      if (!sel) begin
         nxt_r.hold = 1'b0;
      end else if (!sclk_now) begin
         nxt_r.hold = ~pause_n_now;
      end

      if (r_ff.cs_n_lv && sel) begin
         nxt_r.armed = 1'b1;
      end

      if (!sel) begin
         // Deselect drops any partial byte so the next select is clean
         nxt_r.bitcnt  = 3'h0;
         nxt_r.rose    = 1'b0;
         nxt_r.rx_sh   = 8'h00;
         nxt_r.overrun = 1'b0;
         nxt_r.tx_sh   = i_tx_data;
         nxt_r.q       = i_tx_data[7];
         if (r_ff.cs_n_lv == 1'b0) begin
            nxt_r.taken = 1'b0;
         end
      end else if (live) begin
         if (rise) begin
            nxt_r.rx_sh  = {r_ff.rx_sh[6:0], r_ff.dat_s[2]};
            nxt_r.bitcnt = r_ff.bitcnt + 3'h1;
            nxt_r.rose   = 1'b1;
            if (r_ff.bitcnt == 3'h7) begin
               nxt_r.rx_byte = {r_ff.rx_sh[6:0], r_ff.dat_s[2]};
               nxt_r.push    = 1'b1;
               if (!buf_in_ready) begin
                  nxt_r.overrun = 1'b1;
               end
            end
         end
         // A falling edge before any rising one is the idle-high
         // clock leaving its rest level and shifts nothing.
         if (fall && r_ff.rose) begin
            if (r_ff.bitcnt == 3'h0) begin
               nxt_r.tx_sh = i_tx_data;
               nxt_r.q     = i_tx_data[7];
               nxt_r.taken = 1'b1;
            end else begin
               nxt_r.tx_sh = {r_ff.tx_sh[6:0], 1'b1};
               nxt_r.q     = r_ff.tx_sh[6];
            end
         end
      end

      // The select edge itself hands the first byte to the shifter
      if (r_ff.cs_n_lv && sel) begin
         nxt_r.taken = 1'b1;
      end

      // Output driven only when selected and not paused
      nxt_r.q_oe = sel & ~nxt_r.hold;

      // While the protect input is low the guard bits cannot change
      if (i_guard_wr && nxt_r.wp_n_lv) begin
         nxt_r.guard = i_guard_val;
      end

      // Address steps wrap inside the page: one program covers 1..256 bytes
      if (i_addr_load) begin
         nxt_r.addr = i_addr;
      end else if (i_addr_step) begin
         nxt_r.addr[`SF_PAGE_LSB-1:0] = r_ff.addr[`SF_PAGE_LSB-1:0] + 8'h01;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         r_ff            <= '0;
         r_ff.sclk_s     <= '0;
         r_ff.cs_s       <= '1;
         r_ff.pause_s    <= '1;
         r_ff.wp_s       <= '1;
         r_ff.cs_n_lv    <= 1'b1;
         r_ff.pause_n_lv <= 1'b1;
         r_ff.wp_n_lv    <= 1'b1;
         r_ff.tx_sh      <= `SF_TX_IDLE;
         r_ff.q          <= 1'b1;
         r_ff.guard      <= `SF_GUARD_RST;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ****************************************
   // Received byte buffer
   // ****************************************
   two_entry_buf #(
      .W (8),
      .D (2)
   ) u_rx_buf (
      .i_sys_clk   (i_sys_clk),
      .i_rst       (i_rst),
      .i_in_data   (r_ff.rx_byte),
      .i_in_valid  (r_ff.push),
      .o_in_ready  (buf_in_ready),
      .o_out_data  (o_rx_data),
      .o_out_valid (o_rx_valid),
      .i_out_ready (i_rx_ready)
   );

   // ****************************************
   // Outputs
   // ****************************************
   assign link.miso_o       = r_ff.q;
   assign link.miso_oe      = r_ff.q_oe;
   assign o_rx_overrun      = r_ff.overrun;
   assign o_tx_taken        = r_ff.taken;
   assign o_selected        = ~r_ff.cs_n_lv;
   // An internal cycle keeps running through a pause or a deselect
   assign o_active          = ~r_ff.cs_n_lv | i_busy;
   assign o_standby         = r_ff.cs_n_lv & ~i_busy;
   assign o_armed           = r_ff.armed;
   assign o_paused          = r_ff.hold;
   assign o_area_guard      = r_ff.guard;
   assign o_guard_frozen    = ~r_ff.wp_n_lv;
   assign o_addr            = r_ff.addr;
   assign o_sector          = f_sector(r_ff.addr);
   assign o_page            = f_page(r_ff.addr);
   assign o_prog_ok         = (r_ff.guard != `SF_GUARD_ALL);
   assign o_sector_erase_ok = (r_ff.guard != `SF_GUARD_ALL);
   assign o_bulk_erase_ok   = (r_ff.guard == `SF_GUARD_NONE);

endmodule : flash_dev_end

// ===== hw/flash_host_end.sv
`timescale 1ns/100ps

module flash_host_end
   import spi_flash_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst,
   spi_flash_if.host       link,
   input  wire logic       i_cpol,
   input  wire logic [7:0] i_tx_data,
   input  wire logic       i_tx_valid,
   output logic            o_tx_ready,
   input  wire logic       i_pause,
   input  wire logic       i_wp_n,
   output logic [7:0]      o_rx_data,
   output logic            o_rx_valid,
   output logic            o_busy
);

   // ****************************************
   // State
   // ****************************************
   localparam logic [7:0] HALF = 8'(`SF_HALF_CYC);

   host_reg_t r_ff;
   host_reg_t nxt_r;
   logic      half_done;
   logic      last_bit;

   assign half_done  = (r_ff.ph == HALF - 8'h01);
   assign last_bit   = (r_ff.bitn == 3'h7);
   assign o_tx_ready = (r_ff.st == H_IDLE) | ((r_ff.st == H_HIGH) & half_done & last_bit);

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      nxt_r          = r_ff;
      nxt_r.miso_s   = {r_ff.miso_s[1:0], link.miso_line};
      nxt_r.miso_lv  = f_agree(r_ff.miso_s, r_ff.miso_lv);
      nxt_r.rx_valid = 1'b0;
      nxt_r.ph       = r_ff.ph + 8'h01;
      unique case (r_ff.st)
         H_IDLE: begin
            nxt_r.sclk    = i_cpol;
            nxt_r.cpol    = i_cpol;
            nxt_r.cs_n    = 1'b1;
            nxt_r.pause_n = 1'b1;
            nxt_r.ph      = 8'h00;
            if (i_tx_valid) begin
               // Only this one device is selected on the bus
               nxt_r.cs_n = 1'b0;
               nxt_r.sh   = i_tx_data;
               nxt_r.mosi = i_tx_data[7];
               nxt_r.bitn = 3'h0;
               nxt_r.st   = H_LOW;
            end
         end
         H_LOW: begin
            nxt_r.sclk    = 1'b0;
            // Pause only while selected and with the clock low
            nxt_r.pause_n = ~i_pause;
            // A pause restarts the low half: the data line floats meanwhile,
            // so the synchronised copy needs a full half to settle again
            if (!r_ff.pause_n || i_pause) begin
               nxt_r.ph = 8'h00;
            end else if (half_done) begin
               nxt_r.sclk = 1'b1;
               nxt_r.rx   = {r_ff.rx[6:0], r_ff.miso_lv};
               nxt_r.ph   = 8'h00;
               nxt_r.st   = H_HIGH;
            end
         end
         H_HIGH: begin
            if (half_done) begin
               nxt_r.ph = 8'h00;
               if (last_bit) begin
                  nxt_r.rx_data  = r_ff.rx;
                  nxt_r.rx_valid = 1'b1;
                  if (i_tx_valid) begin
                     nxt_r.sh   = i_tx_data;
                     nxt_r.mosi = i_tx_data[7];
                     nxt_r.bitn = 3'h0;
                     nxt_r.sclk = 1'b0;
                     nxt_r.st   = H_LOW;
                  end else begin
                     nxt_r.sclk = r_ff.cpol;
                     nxt_r.st   = H_END;
                  end
               end else begin
                  nxt_r.bitn = r_ff.bitn + 3'h1;
                  nxt_r.sh   = {r_ff.sh[6:0], 1'b0};
                  nxt_r.mosi = r_ff.sh[6];
                  nxt_r.sclk = 1'b0;
                  nxt_r.st   = H_LOW;
               end
            end
         end
         H_END: begin
            // Select released after one half, then a full half deselected
            if (half_done) begin
               nxt_r.cs_n = 1'b1;
            end
            if (r_ff.ph == HALF + HALF - 8'h01) begin
               nxt_r.st = H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         r_ff         <= '0;
         r_ff.st      <= H_IDLE;
         r_ff.cs_n    <= 1'b1;
         r_ff.pause_n <= 1'b1;
         r_ff.miso_s  <= '1;
         r_ff.miso_lv <= 1'b1;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign link.sclk    = r_ff.sclk;
   assign link.cs_n    = r_ff.cs_n;
   assign link.mosi    = r_ff.mosi;
   assign link.pause_n = r_ff.pause_n;
   assign link.wp_n    = i_wp_n;
   assign o_rx_data    = r_ff.rx_data;
   assign o_rx_valid   = r_ff.rx_valid;
   assign o_busy       = (r_ff.st != H_IDLE);

endmodule : flash_host_end

// ===== hw/unused_none.sv
`timescale 1ns/100ps

// ===== tb/spi_link_props.sv
`timescale 1ns/100ps

module spi_link_props (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic pause_n,
   input wire logic wp_n,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic miso_line
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   // ****************************************
   // Device side of the link
   // ****************************************
   a_float_desel: assert property (cs_n [*8] |-> !miso_oe)
      else $error("data line driven while deselected");
   a_drive_on_sel: assert property ($fell(cs_n) && pause_n |-> ##[2:8] miso_oe)
      else $error("data line not driven after select");
   // Host samples on the rise, so the line must hold through the high phase
   a_miso_steady: assert property ($rose(sclk) && !cs_n && !$past(cs_n)
      |=> $stable(miso_line) [*7])
      else $error("data line moved after a rising clock edge");
   a_pause_float: assert property (!pause_n [*8] |-> !miso_oe)
      else $error("data line driven while paused");
   a_pause_exit: assert property ($rose(pause_n) && !cs_n |-> ##[2:10] miso_oe)
      else $error("data line not restored after pause");

   // ****************************************
   // Host side of the link
   // ****************************************
   a_half_period: assert property ($changed(sclk) && !cs_n |=> $stable(sclk) [*8])
      else $error("serial clock half period too short");
   // Outside a frame the clock may only move to a new rest level, well after deselect
   a_clock_in_frame: assert property ($changed(sclk) |-> !cs_n || $past(cs_n, 4))
      else $error("serial clock moved while deselected");
   a_mosi_on_fall: assert property ($changed(mosi) && !cs_n && !$changed(cs_n)
      |-> $fell(sclk))
      else $error("data input moved away from a falling clock edge");
   a_sel_gap: assert property ($rose(cs_n) |=> cs_n [*3])
      else $error("deselect gap too short");
   a_pause_selected: assert property ($fell(pause_n) |-> !cs_n)
      else $error("pause started while deselected");
endmodule : spi_link_props

// ===== tb/tb_top.sv
`timescale 1ns/100ps

module tb_top;
   logic        sys_clk, rst, cpol, h_valid, h_ready, pause, wp_n, h_rxv, h_busy;
   logic        d_rxv, d_rdy, d_ovr, d_taken, busy, d_sel, d_act, d_stby, d_armed;
   logic        d_paused, g_wr, d_frozen, a_load, a_step, d_sector, d_prog, d_serase;
   logic        d_bulk, sink_on, psclk, pcs;
   logic [7:0]  h_tx, h_rx, d_rx, d_tx, d_page, cur;
   logic [1:0]  g_val, d_guard;
   logic [15:0] a_in, d_addr, ra;
   logic [7:0]  devq[$];
   logic [7:0]  hostq[$];
   int          fail_count, tests_run, cyc, rc;

   spi_flash_if spi_flash_if_i ();

   flash_host_end flash_host_end_i (
      .i_sys_clk(sys_clk), .i_rst(rst), .link(spi_flash_if_i.host), .i_cpol(cpol),
      .i_tx_data(h_tx), .i_tx_valid(h_valid), .o_tx_ready(h_ready), .i_pause(pause),
      .i_wp_n(wp_n), .o_rx_data(h_rx), .o_rx_valid(h_rxv), .o_busy(h_busy)
   );

   flash_dev_end flash_dev_end_i (
      .i_sys_clk(sys_clk), .i_rst(rst), .link(spi_flash_if_i.dev), .o_rx_data(d_rx),
      .o_rx_valid(d_rxv), .i_rx_ready(d_rdy), .o_rx_overrun(d_ovr), .i_tx_data(d_tx),
      .o_tx_taken(d_taken), .i_busy(busy), .o_selected(d_sel), .o_active(d_act),
      .o_standby(d_stby), .o_armed(d_armed), .o_paused(d_paused), .i_guard_wr(g_wr),
      .i_guard_val(g_val), .o_area_guard(d_guard), .o_guard_frozen(d_frozen),
      .i_addr_load(a_load), .i_addr(a_in), .i_addr_step(a_step), .o_addr(d_addr),
      .o_sector(d_sector), .o_page(d_page), .o_prog_ok(d_prog),
      .o_sector_erase_ok(d_serase), .o_bulk_erase_ok(d_bulk)
   );

   spi_link_props spi_link_props_i (
      .i_sys_clk(sys_clk), .i_rst(rst), .sclk(spi_flash_if_i.sclk),
      .cs_n(spi_flash_if_i.cs_n), .mosi(spi_flash_if_i.mosi),
      .pause_n(spi_flash_if_i.pause_n), .wp_n(spi_flash_if_i.wp_n),
      .miso_o(spi_flash_if_i.miso_o), .miso_oe(spi_flash_if_i.miso_oe),
      .miso_line(spi_flash_if_i.miso_line)
   );

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // ****************************************
   // Compare and close
   // ****************************************
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic close_out();
      if (fail_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   // A frame is about 180 cycles; the whole run stays far below this
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         close_out();
      end
   end

   // ****************************************
   // Monitors: byte model and wire bit order
   // ****************************************
   always @(negedge sys_clk) begin : mon
      logic nr;
      nr = sink_on && ($urandom_range(1) == 1);
      if (d_rxv === 1'b1 && nr) chk("dev rx", devq.pop_front(), d_rx);
      d_rdy = nr;
      if (h_rxv === 1'b1) chk("host rx", hostq.pop_front(), h_rx);
      if (spi_flash_if_i.cs_n) begin
         rc = 0;
      end else if (spi_flash_if_i.sclk && !psclk && !pcs) begin
         chk("mosi bit", cur[7 - rc], spi_flash_if_i.mosi);
         rc++;
      end
      psclk = spi_flash_if_i.sclk;
      pcs = spi_flash_if_i.cs_n;
   end

   // ****************************************
   // Stimulus tasks
   // ****************************************
   task automatic xfer(input logic [7:0] h, input logic [7:0] d, input bit lost, input bit hold);
      int k;
      int tk;
      @(negedge sys_clk);
      tk = 0;
      d_tx = d;
      h_tx = h;
      h_valid = 1'b1;
      for (k = 0; k < 50 && h_ready !== 1'b1; k++) @(negedge sys_clk);
      cur = h;
      if (!lost) devq.push_back(h);
      hostq.push_back(d);
      @(negedge sys_clk);
      h_valid = 1'b0;
      for (k = 0; k < 700; k++) begin
         if (d_taken === 1'b1) tk++;
         if (k == 20) chk("active", 1, d_act);
         if (k == 20) chk("selected", 1, d_sel);
         if (hold && k == 50) pause = 1'b1;
         if (hold && k == 100) chk("paused", 1, d_paused);
         if (hold && k == 100) chk("pause oe", 0, spi_flash_if_i.miso_oe);
         if (hold && k == 100) chk("pause sel", 1, d_sel);
         if (k == 100) pause = 1'b0;
         if (h_rxv === 1'b1) chk("overrun", lost, d_ovr);
         if (k > 30 && h_busy === 1'b0) break;
         @(negedge sys_clk);
      end
      chk("tx taken", cpol ? 1 : 2, tk);
      chk("idle clock", cpol, spi_flash_if_i.sclk);
      chk("idle oe", 0, spi_flash_if_i.miso_oe);
   endtask : xfer

   task automatic guard(input logic [1:0] v, input logic wp, input logic [1:0] e);
      wp_n = wp;
      repeat (6) @(negedge sys_clk);
      g_val = v;
      g_wr = 1'b1;
      @(negedge sys_clk);
      g_wr = 1'b0;
      @(negedge sys_clk);
      chk("guard", e, d_guard);
      chk("frozen", !wp, d_frozen);
      chk("prog ok", e != 2'h3, d_prog);
      chk("sector erase ok", e != 2'h3, d_serase);
      chk("bulk erase ok", e == 2'h0, d_bulk);
   endtask : guard

   task automatic addr(input logic [15:0] a, input logic ld, input logic st, input logic [15:0] e);
      a_in = a;
      a_load = ld;
      a_step = st;
      @(negedge sys_clk);
      a_load = 1'b0;
      a_step = 1'b0;
      chk("addr", e, d_addr);
      chk("sector", e[15], d_sector);
      chk("page", e[15:8], d_page);
   endtask : addr

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h9e17_d635));
      {rst, wp_n, sink_on} = 3'h7;
      {cpol, h_valid, pause, busy, g_wr, a_load, a_step} = 7'h00;
      {h_tx, d_tx, cur, g_val, a_in} = 42'h0;
      {fail_count, tests_run} = '0;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      chk("armed", 0, d_armed);
      chk("standby", 1, d_stby);
      for (int m = 0; m < 2; m++) begin
         cpol = m[0];
         for (int i = 0; i < 4; i++) xfer(8'($urandom), 8'($urandom), 0, i == 2);
      end
      chk("armed", 1, d_armed);
      busy = 1'b1;
      @(negedge sys_clk);
      chk("busy standby", 0, d_stby);
      chk("busy active", 1, d_act);
      busy = 1'b0;
      @(negedge sys_clk);
      chk("standby", 1, d_stby);
      // Receiver stalls: two bytes fit, the third is lost
      sink_on = 1'b0;
      for (int i = 0; i < 3; i++) xfer(8'($urandom), 8'($urandom), i == 2, 0);
      sink_on = 1'b1;
      repeat (20) @(negedge sys_clk);
      chk("drained", 0, 16'(devq.size()));
      for (int v = 0; v < 4; v++) guard(v[1:0], 1, v[1:0]);
      guard(2'h2, 1, 2'h2);
      guard(2'h3, 0, 2'h2);
      guard(2'h1, 1, 2'h1);
      ra = 16'($urandom);
      addr(ra, 1, 0, ra);
      addr(16'h80ff, 1, 0, 16'h80ff);
      addr(16'h0000, 0, 1, 16'h8000);
      addr(16'h7f34, 1, 1, 16'h7f34);
      for (int s = 0; s < 256; s++) addr(16'h0000, 0, 1, {8'h7f, 8'(8'h35 + s)});
      close_out();
   end
endmodule : tb_top
